// file: src/cbch_pkg.sv
// constants and carrier types for the bridge configuration header block
package cbch_pkg;

  // configuration byte offsets
  localparam logic [7:0] CBCH_OFF_CLS = 8'h0C;
  localparam logic [7:0] CBCH_OFF_LAT = 8'h0D;
  localparam logic [7:0] CBCH_OFF_HDR = 8'h0E;
  localparam logic [7:0] CBCH_OFF_SELF_TEST_CONTROL = 8'h0F;
  localparam logic [7:0] CBCH_OFF_BASE = 8'h10;
  localparam logic [7:0] CBCH_OFF_CAP = 8'h14;
  localparam logic [7:0] CBCH_OFF_SSTAT = 8'h16;
  localparam logic [7:0] CBCH_OFF_EXT = 8'h80;

  // fixed and reset values
  localparam logic [7:0] CBCH_CLS_RST = 8'h00;
  localparam logic [7:0] CBCH_LAT_RST = 8'h00;
  localparam logic [7:0] CBCH_HDR_TYPE = 8'h82;
  localparam logic [7:0] CBCH_SELF_TEST_CONTROL_VAL = 8'h00;
  localparam logic [7:0] CBCH_CAP_PTR = 8'hA0;
  localparam logic [19:0] CBCH_BASE_RST = 20'h00000;
  localparam logic [11:0] CBCH_BASE_LOW = 12'h000;
  localparam logic [1:0] CBCH_SPEED_VAL = 2'h1;
  localparam logic [7:0] CBCH_CNT_MAX = 8'hFF;

  // card-side status field layout
  localparam int CBCH_SS_PARITY = 15;
  localparam int CBCH_SS_SERR = 14;
  localparam int CBCH_SS_MABORT = 13;
  localparam int CBCH_SS_TA_RX = 12;
  localparam int CBCH_SS_TA_SIG = 11;
  localparam int CBCH_SS_SPEED = 9;
  localparam int CBCH_SS_DPAR = 8;
  localparam logic [15:0] CBCH_SS_RC_MASK = 16'hF900;

  // socket window layout
  localparam logic [11:0] CBCH_WIN_LEGACY = 12'h800;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] func;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbch_cfg_req_s;

  typedef struct packed {
    logic parity_err;
    logic card_system_error_flag;
    logic card_master_abort_flag;
    logic card_target_abort_received_flag;
    logic target_abort_sig;
    logic data_parity;
  } cbch_card_evt_s;

endpackage : cbch_pkg

// file: src/cbch_sticky_flag.sv
// one write-one-to-clear status flag, set wins over clear
module cbch_sticky_flag (
  // clock and global reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // set and clear
  input wire logic set_i,
  input wire logic clr_i,
  // state
  output logic flag_o
);
  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : cbch_sticky_flag

// file: src/cbch_config_header.sv
// configuration header registers 0Ch to 17h of the card bridge function
// Operation
// - Cache line size is an 8-bit read/write register that resets to zero.
// - Latency timer is 8-bit read/write and the count starts at zero when the device asserts FRAME as initiator.
// - Once the count has expired during an initiated transaction, it ends when the arbiter removes GNT.
// - Header type is read-only and always returns 82h.
// - Offsets 00h to 7Fh hold the standard header and 80h to FFh hold extension registers.
// - Self-test register is read-only and always returns zero.
// - Window base bits 31 to 12 are read/write, placing the window on any 4-Kbyte boundary.
// - Window base bits 11 to 0 read as zero, so all ones written reads back FFFF F000h.
// - Socket registers decode from window offset 000h and the legacy set from 800h.
// - Capability pointer is read-only and returns A0h.
// - Writing one clears a card-side status flag and writing zero leaves it alone.
// - Card-side status bits 10 to 9 are hardwired to 01b.
// - Card system error, master abort and target abort events set their status flags.
// - Sticky status flags clear only on a write of one or the global reset input, not on soft reset.
module cbch_config_header (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  // configuration access
  input wire cbch_pkg::cbch_cfg_req_s cfg_req_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ext_sel_o,
  // initiator latency
  input wire logic frame_start_i,
  input wire logic init_active_i,
  input wire logic gnt_i,
  output logic lat_expired_o,
  output logic init_stop_o,
  // card-side events
  input wire cbch_pkg::cbch_card_evt_s card_evt_i,
  // socket window decode
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_addr_i,
  output logic win_socket_hit_o,
  output logic win_legacy_hit_o
);
  import cbch_pkg::*;

  logic [7:0] cls_q, cls_d;
  logic [7:0] lat_q, lat_d;
  logic [19:0] base_q, base_d;
  logic [7:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic ext_q, ext_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] ss_set, ss_clr, ss_flags, ss_word;
  logic hit, wr, rd;
  logic [5:0] dw;
  logic win_hit;

  // only function 0 answers in this header
  assign hit = cfg_req_i.valid && (cfg_req_i.func == 3'h0);
  assign wr = hit && cfg_req_i.write;
  assign rd = hit && !cfg_req_i.write;
  assign dw = cfg_req_i.addr[7:2];

  // card-side status flags
  assign ss_set = {card_evt_i.parity_err, card_evt_i.card_system_error_flag,
                   card_evt_i.card_master_abort_flag,
                   card_evt_i.card_target_abort_received_flag,
                   card_evt_i.target_abort_sig, 2'h0, card_evt_i.data_parity,
                   8'h00};
  assign ss_clr = (wr && dw == CBCH_OFF_SSTAT[7:2])
                ? ({{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}}} & cfg_req_i.wdata[31:16])
                : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ss
      if (CBCH_SS_RC_MASK[gi]) begin : g_flag
        // soft reset deliberately not wired here
        cbch_sticky_flag u_flag (
          .ref_clk_i(ref_clk_i),
          .reset_i(reset_i),
          .set_i(ss_set[gi]),
          .clr_i(ss_clr[gi]),
          .flag_o(ss_flags[gi])
        );
      end else begin : g_zero
        assign ss_flags[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    ss_word = ss_flags;
    ss_word[CBCH_SS_SPEED +: 2] = CBCH_SPEED_VAL;
  end

  // register writes and read data
  always_comb begin
    cls_d = cls_q;
    lat_d = lat_q;
    base_d = base_q;
    ack_d = hit;
    ext_d = hit && (cfg_req_i.addr >= CBCH_OFF_EXT);
    rdata_d = rdata_q;
    if (wr && dw == CBCH_OFF_CLS[7:2]) begin
      if (cfg_req_i.be[0]) begin
        cls_d = cfg_req_i.wdata[7:0];
      end
      if (cfg_req_i.be[1]) begin
        lat_d = cfg_req_i.wdata[15:8];
      end
    end
    if (wr && dw == CBCH_OFF_BASE[7:2]) begin
      // low byte and bits 11:8 are not storage
      if (cfg_req_i.be[1]) begin
        base_d[3:0] = cfg_req_i.wdata[15:12];
      end
      if (cfg_req_i.be[2]) begin
        base_d[11:4] = cfg_req_i.wdata[23:16];
      end
      if (cfg_req_i.be[3]) begin
        base_d[19:12] = cfg_req_i.wdata[31:24];
      end
    end
    if (rd) begin
      unique case (dw)
        CBCH_OFF_CLS[7:2]: rdata_d = {CBCH_SELF_TEST_CONTROL_VAL, CBCH_HDR_TYPE, lat_q, cls_q};
        CBCH_OFF_BASE[7:2]: rdata_d = {base_q, CBCH_BASE_LOW};
        CBCH_OFF_CAP[7:2]: rdata_d = {ss_word, 8'h00, CBCH_CAP_PTR};
        // other header and extension offsets are answered elsewhere
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (soft_reset_i) begin
      cls_d = CBCH_CLS_RST;
      lat_d = CBCH_LAT_RST;
      base_d = CBCH_BASE_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cls_q <= CBCH_CLS_RST;
      lat_q <= CBCH_LAT_RST;
      base_q <= CBCH_BASE_RST;
      ack_q <= 1'b0;
      ext_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      cls_q <= cls_d;
      lat_q <= lat_d;
      base_q <= base_d;
      ack_q <= ack_d;
      ext_q <= ext_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack_o = ack_q;
  assign cfg_rdata_o = rdata_q;
  assign cfg_ext_sel_o = ext_q;

  // initiator latency counter, saturates so it never wraps back under the limit
  always_comb begin
    cnt_d = cnt_q;
    if (frame_start_i) begin
      cnt_d = 8'h00;
    end else if (init_active_i && cnt_q != CBCH_CNT_MAX) begin
      cnt_d = cnt_q + 8'h01;
    end
    if (soft_reset_i) begin
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign lat_expired_o = init_active_i && (cnt_q >= lat_q);
  assign init_stop_o = lat_expired_o && !gnt_i;

  // window decode, 4-Kbyte aligned
  assign win_hit = mem_valid_i && (mem_addr_i[31:12] == base_q);
  assign win_socket_hit_o = win_hit && (mem_addr_i[11:0] < CBCH_WIN_LEGACY);
  assign win_legacy_hit_o = win_hit && (mem_addr_i[11:0] >= CBCH_WIN_LEGACY);

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_CLS_WRITE: assert property (wr && dw == 6'h03 && cfg_req_i.be[0] && !soft_reset_i
    |=> cls_q == $past(cfg_req_i.wdata[7:0])) else $error("cache line size not stored");
  AST_CNT_START: assert property (frame_start_i && !soft_reset_i
    |=> cnt_q == 8'h00) else $error("latency count did not restart");
  AST_STOP_CAUSE: assert property (init_stop_o |-> !gnt_i && init_active_i && cnt_q >= lat_q)
    else $error("stop without expiry and grant removal");
  AST_NO_EARLY_STOP: assert property (frame_start_i && !soft_reset_i ##1 init_active_i
    && lat_q != 8'h00 |-> !init_stop_o) else $error("stop before latency count ran");
  AST_HDR_SELF_TEST_CONTROL: assert property (rd && dw == 6'h03
    |=> cfg_ack_o && cfg_rdata_o[31:16] == 16'h0082) else $error("header or self-test wrong");
  AST_BASE_LOW: assert property (rd && dw == 6'h04 |=> cfg_rdata_o[11:0] == 12'h000)
    else $error("base low bits not zero");
  AST_CAP_SPEED: assert property (rd && dw == 6'h05
    |=> cfg_rdata_o[7:0] == 8'hA0 && cfg_rdata_o[26:25] == 2'b01)
    else $error("capability pointer or speed field wrong");
  AST_SET_WINS: assert property (card_evt_i.card_master_abort_flag
    |=> ss_flags[13] [*1]) else $error("master abort event lost");
  AST_ZERO_KEEPS: assert property (wr && dw == 6'h05 && ss_flags[14] && !cfg_req_i.wdata[30]
    |=> ss_flags[14]) else $error("zero write cleared a flag");
  AST_ONE_CLEARS: assert property (wr && dw == 6'h05 && cfg_req_i.be[3] && cfg_req_i.wdata[31]
    && !card_evt_i.parity_err |=> !ss_flags[15]) else $error("one write did not clear");
  AST_SOFT_KEEPS: assert property (soft_reset_i && ss_flags[12] && !ss_clr[12] |=> ss_flags[12])
    else $error("soft reset cleared sticky flag");
  AST_WIN_LEGACY: assert property (mem_valid_i && mem_addr_i[31:12] == base_q
    && mem_addr_i[11] |-> win_legacy_hit_o && !win_socket_hit_o)
    else $error("legacy window decode wrong");

  COV_STOP: cover property (frame_start_i ##[1:20] init_stop_o);
  COV_CLEAR: cover property (ss_flags[14] ##1 wr && dw == 6'h05 ##1 !ss_flags[14]);
  COV_BASE_ONES: cover property (rd && dw == 6'h04 ##1 cfg_rdata_o == 32'hFFFFF000);

endmodule : cbch_config_header

// file: tb/cbch_host_model.sv
// host configuration master model for the bridge header block
module cbch_host_model (
  // clock
  input wire logic ref_clk_i,
  // configuration bus
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_ext_i,
  output cbch_pkg::cbch_cfg_req_s cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cbch_pkg::*;
  logic ext_seen = 1'b0;
  initial cfg_req_o = '0;
  // one access; idle fields other than func are inverted so stale values never pass
  task automatic xfer(input logic [2:0] f, input logic w, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic ack, output logic [31:0] rd);
    @(posedge ref_clk_i);
    cfg_req_o <= '{1'b1, w, f, a, be, wd};
    @(posedge ref_clk_i);
    cfg_req_o <= '{1'b0, ~w, f, ~a, ~be, ~wd};
    // answer stands one cycle, so sample it settled, not at the next edge
    #1;
    ack = cfg_ack_i;
    rd = cfg_rdata_i;
    ext_seen = cfg_ext_i;
    @(posedge ref_clk_i);
  endtask : xfer
endmodule : cbch_host_model

// file: tb/cbch_config_header_bench.sv
// self-checking bench for the bridge configuration header block
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  $display("FAIL %s exp %h got %h", nm, ex, got); miscompares++; end end
module cbch_config_header_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cbch_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] ex;
  } cbch_row_s;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic soft_reset_i = 1'b0;
  logic frame_start = 1'b0;
  logic init_active = 1'b0;
  logic gnt = 1'b1;
  logic mem_valid = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  cbch_card_evt_s card_evt = '0;
  cbch_cfg_req_s cfg_req;
  logic ack, expired, stop, s_hit, l_hit, ack_v, ext;
  logic [31:0] rdata, rd_v;
  int miscompares = 0;
  int cmp_count = 0;
  // byte enables matter: row four only touches bits 15:12
  cbch_row_s rows [6] = '{
    '{8'h0C, 4'hF, 32'hFFFF_FFFF, 32'h0082_FFFF},
    '{8'h0C, 4'h1, 32'h0000_0040, 32'h0082_FF40},
    '{8'h10, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_F000},
    '{8'h10, 4'h2, 32'h1234_5678, 32'hFFFF_5000},
    '{8'h14, 4'hF, 32'hFFFF_FFFF, 32'h0200_00A0},
    '{8'h80, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
  cbch_config_header dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .cfg_req_i(cfg_req), .cfg_ack_o(ack),
    .cfg_rdata_o(rdata), .cfg_ext_sel_o(ext), .frame_start_i(frame_start),
    .init_active_i(init_active), .gnt_i(gnt), .lat_expired_o(expired),
    .init_stop_o(stop), .card_evt_i(card_evt), .mem_valid_i(mem_valid),
    .mem_addr_i(mem_addr), .win_socket_hit_o(s_hit), .win_legacy_hit_o(l_hit));
  cbch_host_model host (.ref_clk_i(ref_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
    .cfg_ext_i(ext), .cfg_req_o(cfg_req));
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    host.xfer(3'h0, 1'b0, a, 4'hF, 32'h0, ack_v, rd_v);
    `CHK("ack", 1'b1, ack_v)
    `CHK("rdata", ex, rd_v)
    `CHK("ext_sel", a >= CBCH_OFF_EXT, host.ext_seen)
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    host.xfer(3'h0, 1'b1, a, be, wd, ack_v, rd_v);
  endtask : wr
  task automatic win(input logic [31:0] a, input logic s, input logic l);
    @(posedge ref_clk_i);
    mem_valid <= 1'b1;
    mem_addr <= a;
    #1;
    `CHK("socket_hit", s, s_hit)
    `CHK("legacy_hit", l, l_hit)
  endtask : win
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_chk(CBCH_OFF_CLS, 32'h0082_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].be, rows[i].wd);
      rd_chk(rows[i].a, rows[i].ex);
    end
    win(32'hFFFF_5004, 1'b1, 1'b0);
    win(32'hFFFF_5800, 1'b0, 1'b1);
    win(32'hFFFF_6000, 1'b0, 1'b0);
    host.xfer(3'h1, 1'b0, CBCH_OFF_CLS, 4'hF, 32'h0, ack_v, rd_v);
    `CHK("other_func_ack", 1'b0, ack_v)
    wr(CBCH_OFF_CLS, 4'h2, 32'h0000_0200);
    @(posedge ref_clk_i);
    frame_start <= 1'b1;
    init_active <= 1'b1;
    @(posedge ref_clk_i);
    frame_start <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK("expired_early", 1'b0, expired)
    @(posedge ref_clk_i);
    #1;
    `CHK("expired", 1'b1, expired)
    `CHK("stop_granted", 1'b0, stop)
    @(posedge ref_clk_i);
    gnt <= 1'b0;
    #1;
    `CHK("stop", 1'b1, stop)
    @(posedge ref_clk_i);
    init_active <= 1'b0;
    gnt <= 1'b1;
    card_evt <= 6'h3F;
    @(posedge ref_clk_i);
    card_evt <= '0;
    rd_chk(CBCH_OFF_CAP, 32'hFB00_00A0);
    wr(CBCH_OFF_CAP, 4'h8, 32'h2000_0000);
    rd_chk(CBCH_OFF_CAP, 32'hDB00_00A0);
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    rd_chk(CBCH_OFF_CAP, 32'hDB00_00A0);
    rd_chk(CBCH_OFF_CLS, 32'h0082_0000);
    wr(CBCH_OFF_BASE, 4'hF, 32'hFFFF_FFFF);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_chk(CBCH_OFF_CAP, 32'h0200_00A0);
    rd_chk(CBCH_OFF_BASE, 32'h0000_0000);
    // event and write-one clear in one cycle, set must win
    fork
      wr(CBCH_OFF_CAP, 4'h8, 32'h8000_0000);
      begin
        @(posedge ref_clk_i);
        card_evt <= 6'h20;
        @(posedge ref_clk_i);
        card_evt <= '0;
      end
    join
    rd_chk(CBCH_OFF_CAP, 32'h8200_00A0);
    tally_and_finish();
  end
endmodule : cbch_config_header_bench
